// ==== rtl/fsp_pkg.sv ====
// package for the flash self-program sequencer: register map, fields, timing
package fsp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_MAIN = 4'h0;
    localparam logic [3:0] ADDR_CTRL_AUX = 4'h1;
    localparam logic [3:0] ADDR_FLASH_ADDR_LOW = 4'h2;
    localparam logic [3:0] ADDR_FLASH_ADDR_HIGH = 4'h3;
    localparam logic [3:0] ADDR_DATA_WORD0_LOW = 4'h4;
    localparam logic [3:0] ADDR_DATA_WORD0_HIGH = 4'h5;
    localparam logic [3:0] ADDR_DATA_WORD1_LOW = 4'h6;
    localparam logic [3:0] ADDR_DATA_WORD1_HIGH = 4'h7;
    localparam logic [3:0] ADDR_DATA_WORD2_LOW = 4'h8;
    localparam logic [3:0] ADDR_DATA_WORD2_HIGH = 4'h9;
    localparam logic [3:0] ADDR_DATA_WORD3_LOW = 4'ha;
    localparam logic [3:0] ADDR_DATA_WORD3_HIGH = 4'hb;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLED = 7;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_UNLOCK_TRIGGER = 3;
    localparam int BIT_WRITE_START = 2;
    localparam int BIT_TIMING_SELECT = 1;
    localparam int BIT_BUFFER_CLEAR = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // operation modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_PAGE_ERASE = 3'h1;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;

    // ------------------------------------------------------------
    // unlock key, in write order
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_B0 = 8'h00;
    localparam logic [7:0] KEY_B1 = 8'h0d;
    localparam logic [7:0] KEY_B2 = 8'hc3;
    localparam logic [7:0] KEY_B3 = 8'h04;
    localparam logic [7:0] KEY_B4 = 8'h09;
    localparam logic [7:0] KEY_B5 = 8'h40;

    // ------------------------------------------------------------
    // page geometry and timing
    // ------------------------------------------------------------
    localparam int PAGE_WORDS = 64;
    localparam logic [5:0] PAGE_LAST = 6'h3f;
    localparam int CLK_HZ = 25000000;
    localparam int ERASE_SHORT_US = 3200;
    localparam int WRITE_SHORT_US = 2200;
    localparam int ERASE_LONG_US = 3700;
    localparam int WRITE_LONG_US = 3000;
    localparam int ERASE_SHORT_CYC = ERASE_SHORT_US * (CLK_HZ / 1000000);
    localparam int WRITE_SHORT_CYC = WRITE_SHORT_US * (CLK_HZ / 1000000);
    localparam int ERASE_LONG_CYC = ERASE_LONG_US * (CLK_HZ / 1000000);
    localparam int WRITE_LONG_CYC = WRITE_LONG_US * (CLK_HZ / 1000000);
    localparam int UNLOCK_WINDOW_CYC = 64;

    typedef struct packed {
        logic we;
        logic re;
        logic [3:0] addr;
        logic [7:0] wdata;
    } fsp_bus_type;

    typedef struct packed {
        logic start;
        logic erase;
        logic [8:0] page;
        logic [63:0] tag;
    } fsp_op_type;

endpackage

// ==== rtl/fsp_sequencer.sv ====
// flash self-program sequencer: address, data, page buffer, unlock and erase/write timing
// How it works
// (R1) high address register keeps address bits 14..8; bit 7 reads zero
// (R2) low data byte write of word 0 only stores the register
// (R3) high data byte write of word 0 loads word into buffer, bumps address
// (R4) dummy high byte writes tag the current address for erase, advance address
// (R5) address stops incrementing at last word of page
// (R6) erased words read 0000h; software blank-checks and repeats erase
// (R7) correct unlock sets enabled bit; erase/write only while it is high
// (R8) software writes mode code 110 before unlocking
// (R9) setting unlock trigger starts the unlock window timer
// (R10) key 00,0d,c3,04,09,40 into words 1..3 low then 1..3 high
// (R11) software writes the six key bytes back to back after trigger
// (R12) unlock trigger clears itself when the window timer expires
// (R13) a wrong key byte leaves erase/write disabled
// (R14) clearing the enabled bit disables erase/write at once
// (R15) buffer holds 64 words, page chosen by address bits 14..6
// (R16) software matches buffered data to the addressed page
// (R17) software erases the page before loading and writing
// (R18) buffer-clear bit empties the write buffer for a retry
// (R19) mode field: 000 write, 001 erase, 011 read, 110 unlock
// (R20) write start set by software, cleared when operation completes
// (R21) timing select: 3.2/2.2 ms or 3.7/3.0 ms erase/write
// (R22) writing one to the enabled bit has no effect
// (R23) address increment never carries out of bits 5..0, as it stops at the last word of the page
// (R24) unlock window length is a parameter
// (R25) data registers read/write, reset to zero
`timescale 1ns/100ps
module fsp_sequencer #(
    parameter int UNLOCK_CYC = fsp_pkg::UNLOCK_WINDOW_CYC,
    parameter int ERASE_SHORT = fsp_pkg::ERASE_SHORT_CYC,
    parameter int WRITE_SHORT = fsp_pkg::WRITE_SHORT_CYC,
    parameter int ERASE_LONG = fsp_pkg::ERASE_LONG_CYC,
    parameter int WRITE_LONG = fsp_pkg::WRITE_LONG_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    output logic flash_op_start,
    output logic flash_op_erase,
    output logic [8:0] flash_op_page,
    output logic [63:0] flash_erase_tag,
    output logic [15:0] flash_buf_word [fsp_pkg::PAGE_WORDS],
    output logic [63:0] flash_buf_valid,
    output logic flash_busy
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    fsp_pkg::fsp_bus_type bus;
    assign bus = '{we: reg_we, re: reg_re, addr: reg_addr, wdata: reg_wdata};

    function automatic logic wr_to(input fsp_pkg::fsp_bus_type b, input logic [3:0] a);
        return b.we && (b.addr == a);
    endfunction

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} fsp_state_type;
    fsp_state_type state_q;

    logic [7:0] data_q [8];
    logic [14:0] faddr_q;
    logic [2:0] mode_q;
    logic enabled_q;
    logic trigger_q;
    logic write_start_q;
    logic timing_q;
    logic clear_q;
    logic [15:0] unlock_cnt_q;
    logic [5:0] key_ok_q;
    logic [2:0] key_idx_q;
    logic [17:0] op_cnt_q;
    logic [15:0] buf_q [fsp_pkg::PAGE_WORDS];
    logic [63:0] valid_q;
    logic [63:0] tag_q;

    logic hi0_wr;
    logic at_page_end;
    logic op_done;
    assign hi0_wr = wr_to(bus, fsp_pkg::ADDR_DATA_WORD0_HIGH);
    assign at_page_end = (faddr_q[5:0] == fsp_pkg::PAGE_LAST);

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                data_q[i] <= fsp_pkg::RESET_BYTE; // R25
            end
        end else if (bus.we && bus.addr >= fsp_pkg::ADDR_DATA_WORD0_LOW
                     && bus.addr <= fsp_pkg::ADDR_DATA_WORD3_HIGH) begin
            data_q[3'(bus.addr - fsp_pkg::ADDR_DATA_WORD0_LOW)] <= bus.wdata; // R2 R25
        end
    end

    // ------------------------------------------------------------
    // flash address
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            faddr_q <= 15'h0000;
        end else if (wr_to(bus, fsp_pkg::ADDR_FLASH_ADDR_LOW)) begin
            faddr_q[7:0] <= bus.wdata;
        end else if (wr_to(bus, fsp_pkg::ADDR_FLASH_ADDR_HIGH)) begin
            faddr_q[14:8] <= bus.wdata[6:0]; // R1
        end else if (hi0_wr && !at_page_end) begin
            faddr_q <= faddr_q + 15'h0001; // R3 R4 R5 R23
        end
    end

    // ------------------------------------------------------------
    // page buffer and erase tags
    // ------------------------------------------------------------
    // buffer empties after each operation and on explicit clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 64'h0;
            tag_q <= 64'h0;
        end else if (clear_q || op_done) begin
            valid_q <= 64'h0; // R18
            tag_q <= 64'h0;
        end else if (hi0_wr) begin
            valid_q[faddr_q[5:0]] <= 1'b1; // R15
            tag_q[faddr_q[5:0]] <= 1'b1; // R4
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hi0_wr) begin
            buf_q[faddr_q[5:0]] <= {bus.wdata, data_q[0]}; // R3
        end
    end

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 3'h0;
            timing_q <= 1'b0;
            clear_q <= 1'b0;
        end else begin
            if (wr_to(bus, fsp_pkg::ADDR_CTRL_MAIN)) begin
                mode_q <= bus.wdata[fsp_pkg::BIT_MODE_HI:fsp_pkg::BIT_MODE_LO]; // R19
            end
            if (wr_to(bus, fsp_pkg::ADDR_CTRL_AUX)) begin
                timing_q <= bus.wdata[fsp_pkg::BIT_TIMING_SELECT]; // R21
                clear_q <= bus.wdata[fsp_pkg::BIT_BUFFER_CLEAR];
            end else begin
                clear_q <= 1'b0; // one-cycle clear process
            end
        end
    end

    // ------------------------------------------------------------
    // unlock window and key check
    // ------------------------------------------------------------
    logic key_wr;
    logic [2:0] key_slot;
    logic [7:0] key_exp;
    always_comb begin
        key_wr = 1'b0;
        key_slot = 3'h0;
        key_exp = fsp_pkg::KEY_B0;
        if (bus.we) begin
            unique case (bus.addr)
                fsp_pkg::ADDR_DATA_WORD1_LOW: begin key_wr = 1'b1; key_slot = 3'h0; key_exp = fsp_pkg::KEY_B0; end
                fsp_pkg::ADDR_DATA_WORD2_LOW: begin key_wr = 1'b1; key_slot = 3'h1; key_exp = fsp_pkg::KEY_B1; end
                fsp_pkg::ADDR_DATA_WORD3_LOW: begin key_wr = 1'b1; key_slot = 3'h2; key_exp = fsp_pkg::KEY_B2; end
                fsp_pkg::ADDR_DATA_WORD1_HIGH: begin key_wr = 1'b1; key_slot = 3'h3; key_exp = fsp_pkg::KEY_B3; end
                fsp_pkg::ADDR_DATA_WORD2_HIGH: begin key_wr = 1'b1; key_slot = 3'h4; key_exp = fsp_pkg::KEY_B4; end
                fsp_pkg::ADDR_DATA_WORD3_HIGH: begin key_wr = 1'b1; key_slot = 3'h5; key_exp = fsp_pkg::KEY_B5; end
                default: key_wr = 1'b0;
            endcase
        end
    end

    logic trig_set;
    logic key_done;
    assign trig_set = wr_to(bus, fsp_pkg::ADDR_CTRL_MAIN) && bus.wdata[fsp_pkg::BIT_UNLOCK_TRIGGER]
                      && !trigger_q;
    assign key_done = trigger_q && key_wr && key_slot == 3'h5 && key_idx_q == 3'h5
                      && key_ok_q[4:0] == 5'h1f && bus.wdata == key_exp;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trigger_q <= 1'b0;
            unlock_cnt_q <= 16'h0;
            key_ok_q <= 6'h0;
            key_idx_q <= 3'h0;
        end else if (trig_set) begin
            trigger_q <= 1'b1; // R9
            unlock_cnt_q <= 16'(UNLOCK_CYC); // R24
            key_ok_q <= 6'h0;
            key_idx_q <= 3'h0;
        end else if (trigger_q) begin
            if (unlock_cnt_q == 16'h1) begin
                trigger_q <= 1'b0; // R12
            end
            unlock_cnt_q <= unlock_cnt_q - 16'h1;
            if (key_wr && key_idx_q != 3'h6) begin
                // out-of-order byte lands in the wrong slot and spoils the key
                key_ok_q[key_idx_q] <= (key_slot == key_idx_q) && (bus.wdata == key_exp); // R10 R13
                key_idx_q <= key_idx_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // enabled status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enabled_q <= 1'b0;
        end else if (key_done && mode_q == fsp_pkg::MODE_UNLOCK) begin
            enabled_q <= 1'b1; // R7 R8
        end else if (wr_to(bus, fsp_pkg::ADDR_CTRL_MAIN) && !bus.wdata[fsp_pkg::BIT_ENABLED]) begin
            enabled_q <= 1'b0; // R14 R22
        end
    end

    // ------------------------------------------------------------
    // erase/write timing
    // ------------------------------------------------------------
    logic op_req;
    logic op_is_erase;
    logic [17:0] op_len;
    assign op_is_erase = (mode_q == fsp_pkg::MODE_PAGE_ERASE);
    assign op_req = write_start_q && state_q == ST_IDLE && enabled_q
                    && (op_is_erase || mode_q == fsp_pkg::MODE_WRITE); // R7 R19
    always_comb begin
        if (op_is_erase) begin
            op_len = timing_q ? 18'(ERASE_LONG) : 18'(ERASE_SHORT); // R21
        end else begin
            op_len = timing_q ? 18'(WRITE_LONG) : 18'(WRITE_SHORT); // R21
        end
    end
    assign op_done = (state_q == ST_DONE);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            op_cnt_q <= 18'h0;
            flash_op_erase <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (op_req) begin
                        state_q <= ST_BUSY;
                        op_cnt_q <= op_len;
                        flash_op_erase <= op_is_erase; // R6
                    end
                end
                ST_BUSY: begin
                    if (op_cnt_q <= 18'h1) begin
                        state_q <= ST_DONE;
                    end
                    op_cnt_q <= op_cnt_q - 18'h1;
                end
                ST_DONE: state_q <= ST_IDLE;
            endcase
        end
    end

    // a start without enable or in a non-erase/write mode is dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            write_start_q <= 1'b0;
        end else if (op_done || (write_start_q && state_q == ST_IDLE && !op_req)) begin
            write_start_q <= 1'b0; // R20
        end else if (wr_to(bus, fsp_pkg::ADDR_CTRL_MAIN) && bus.wdata[fsp_pkg::BIT_WRITE_START]) begin
            write_start_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_op_start <= 1'b0;
            flash_op_page <= 9'h0;
        end else begin
            flash_op_start <= op_req;
            if (op_req) begin
                flash_op_page <= faddr_q[14:6]; // R15
            end
        end
    end
    assign flash_busy = (state_q != ST_IDLE);
    assign flash_erase_tag = tag_q;
    assign flash_buf_valid = valid_q;
    assign flash_buf_word = buf_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (bus.re) begin
            unique case (bus.addr)
                fsp_pkg::ADDR_CTRL_MAIN:
                    reg_rdata <= {enabled_q, mode_q, trigger_q, write_start_q, 2'b00};
                fsp_pkg::ADDR_CTRL_AUX: reg_rdata <= {6'h00, timing_q, clear_q};
                fsp_pkg::ADDR_FLASH_ADDR_LOW: reg_rdata <= faddr_q[7:0];
                fsp_pkg::ADDR_FLASH_ADDR_HIGH: reg_rdata <= {1'b0, faddr_q[14:8]}; // R1
                default: begin
                    if (bus.addr >= fsp_pkg::ADDR_DATA_WORD0_LOW && bus.addr <= fsp_pkg::ADDR_DATA_WORD3_HIGH) begin
                        reg_rdata <= data_q[3'(bus.addr - fsp_pkg::ADDR_DATA_WORD0_LOW)];
                    end else begin
                        reg_rdata <= 8'h00;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_addr_inc;
        @(posedge clk_sys) disable iff (!rst_n)
        hi0_wr && !at_page_end |=> faddr_q == $past(faddr_q) + 15'h0001;
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address did not advance"); // R3

    property p_page_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        hi0_wr && at_page_end |=> $stable(faddr_q);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("address passed page end"); // R5

    property p_buf_load;
        @(posedge clk_sys) disable iff (!rst_n)
        hi0_wr && !clear_q && !op_done |=> valid_q[$past(faddr_q[5:0])];
    endproperty
    a_buf_load: assert property (p_buf_load) else $error("word not buffered"); // R3

    property p_low_no_load;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_to(bus, fsp_pkg::ADDR_DATA_WORD0_LOW) && !clear_q && !op_done |=> $stable(valid_q);
    endproperty
    a_low_no_load: assert property (p_low_no_load) else $error("low byte touched buffer"); // R2

    property p_no_sw_enable;
        @(posedge clk_sys) disable iff (!rst_n)
        !enabled_q && !key_done |=> !enabled_q;
    endproperty
    a_no_sw_enable: assert property (p_no_sw_enable) else $error("enable set without key"); // R22

    property p_disable;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_to(bus, fsp_pkg::ADDR_CTRL_MAIN) && !bus.wdata[fsp_pkg::BIT_ENABLED] && !key_done |=> !enabled_q;
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not take"); // R14

    property p_op_needs_enable;
        @(posedge clk_sys) disable iff (!rst_n)
        flash_op_start |-> $past(enabled_q);
    endproperty
    a_op_needs_enable: assert property (p_op_needs_enable) else $error("operation while locked"); // R7

    property p_trigger_ends;
        @(posedge clk_sys) disable iff (!rst_n)
        trigger_q && unlock_cnt_q == 16'h1 && !trig_set |=> !trigger_q;
    endproperty
    a_trigger_ends: assert property (p_trigger_ends) else $error("trigger outlived window"); // R12

    property p_start_clears;
        @(posedge clk_sys) disable iff (!rst_n)
        op_done |=> !write_start_q && valid_q == 64'h0;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start bit not cleared"); // R20

endmodule // fsp_sequencer

// ==== tb/fsp_flash_model.sv ====
// behavioural program flash array behind the sequencer
`timescale 1ns/100ps
module fsp_flash_model (
    input wire logic clk_sys,
    input wire logic flash_op_start,
    input wire logic flash_op_erase,
    input wire logic [8:0] flash_op_page,
    input wire logic [63:0] flash_erase_tag,
    input wire logic [15:0] flash_buf_word [fsp_pkg::PAGE_WORDS],
    input wire logic [63:0] flash_buf_valid,
    input wire logic [14:0] rd_addr,
    output logic [15:0] rd_data
);
    // --------
    // array
    // --------
    logic [15:0] mem [32768];
    initial begin
        // non-blank start so a missed erase shows
        for (int i = 0; i < 32768; i++) begin
            mem[i] = ~i[15:0];
        end
    end
    always @(posedge clk_sys) begin
        if (flash_op_start === 1'b1) begin
            for (int w = 0; w < 64; w++) begin
                if (flash_op_erase && flash_erase_tag[w]) begin
                    mem[{flash_op_page, w[5:0]}] = 16'h0000;
                end
                if (!flash_op_erase && flash_buf_valid[w]) begin
                    mem[{flash_op_page, w[5:0]}] = flash_buf_word[w];
                end
            end
        end
    end
    assign rd_data = mem[rd_addr];
endmodule // fsp_flash_model

// ==== tb/tb_flash_selfprogram_erase_write.sv ====
// self-checking bench for the flash self-program sequencer
`timescale 1ns/100ps
module tb_flash_selfprogram_erase_write;
    localparam int ES = 20, WS = 14, EL = 30, WL = 24;
    localparam logic [3:0] CM = fsp_pkg::ADDR_CTRL_MAIN, CA = fsp_pkg::ADDR_CTRL_AUX;
    localparam logic [3:0] AL = fsp_pkg::ADDR_FLASH_ADDR_LOW, AH = fsp_pkg::ADDR_FLASH_ADDR_HIGH;
    localparam logic [3:0] DL = fsp_pkg::ADDR_DATA_WORD0_LOW, DH = fsp_pkg::ADDR_DATA_WORD0_HIGH;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_rdata;
    logic flash_op_start;
    logic flash_op_erase;
    logic [8:0] flash_op_page;
    logic [63:0] flash_erase_tag;
    logic [15:0] flash_buf_word [fsp_pkg::PAGE_WORDS];
    logic [63:0] flash_buf_valid;
    logic flash_busy;
    logic [14:0] rd_addr = 15'h0000;
    logic [15:0] rd_data;
    logic [7:0] rv;
    logic seen_erase = 1'b0;
    logic [8:0] seen_page = 9'h000;
    int fails = 0;
    int compares = 0;
    int starts = 0;
    int busy_n = 0;

    always #20 clk_sys = ~clk_sys;

    fsp_sequencer #(.ERASE_SHORT(ES), .WRITE_SHORT(WS), .ERASE_LONG(EL), .WRITE_LONG(WL)) u_dut (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .flash_op_start,
        .flash_op_erase, .flash_op_page, .flash_erase_tag, .flash_buf_word, .flash_buf_valid, .flash_busy);
    fsp_flash_model u_flash (
        .clk_sys, .flash_op_start, .flash_op_erase, .flash_op_page, .flash_erase_tag, .flash_buf_word,
        .flash_buf_valid, .rd_addr, .rd_data);

    // --------
    // operation monitor
    // --------
    always @(posedge clk_sys) begin
        if (flash_op_start === 1'b1) begin
            starts <= starts + 1;
            seen_erase <= flash_op_erase;
            seen_page <= flash_op_page;
            busy_n <= 0;
        end else if (flash_busy === 1'b1) begin
            busy_n <= busy_n + 1;
        end
    end

    // --------
    // bus and check tasks
    // --------
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk_sys);
        reg_we <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1;
        rv = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, exp, rv);
    endtask
    // go low: wait ten cycles and expect no operation at all
    task automatic run_op(input logic [7:0] ctl, input logic go, output int len);
        int s0;
        int n;
        s0 = starts;
        n = 0;
        wr(CM, ctl);
        while (n < 300 && (go ? (starts == s0 || flash_busy !== 1'b0) : n < 10)) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        len = busy_n;
        if (go && n == 300) begin
            fails++;
            $display("BAD op done expected 1 seen 0");
            complete_run();
        end else begin
            chk("op count", go ? s0 + 1 : s0, starts);
        end
    endtask
    task automatic unlock(input logic [7:0] last, input logic [7:0] en);
        int n;
        wr(CM, 8'h68);
        wr(fsp_pkg::ADDR_DATA_WORD1_LOW, fsp_pkg::KEY_B0);
        wr(fsp_pkg::ADDR_DATA_WORD2_LOW, fsp_pkg::KEY_B1);
        wr(fsp_pkg::ADDR_DATA_WORD3_LOW, fsp_pkg::KEY_B2);
        wr(fsp_pkg::ADDR_DATA_WORD1_HIGH, fsp_pkg::KEY_B3);
        wr(fsp_pkg::ADDR_DATA_WORD2_HIGH, fsp_pkg::KEY_B4);
        wr(fsp_pkg::ADDR_DATA_WORD3_HIGH, last);
        rdc("ctrl after key", CM, en | 8'h68);
        n = 0;
        while (rv[3] !== 1'b0 && n < 60) begin
            rd(CM);
            n++;
        end
        chk("trigger end", en | 8'h60, rv);
        chk("window", 1'b1, n > 20 && n < 30);
        if (n == 60) begin
            complete_run();
        end
    endtask
    task automatic tag_page();
        wr(AL, 8'h80);
        wr(AH, 8'h00);
        for (int i = 0; i < 64; i++) begin
            wr(DH, 8'h00);
        end
        #1;
        chk("tags", {64{1'b1}}, flash_erase_tag);
    endtask
    task automatic load3();
        wr(AL, 8'h80);
        wr(AH, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(DL, 8'h05 + 8'(i));
            wr(DH, 8'ha0 + 8'(i));
        end
    endtask

    // --------
    // scenarios
    // --------
    task automatic t_regs();
        for (int a = 0; a < 12; a++) begin
            rdc("reset value", a[3:0], 8'h00);
        end
        wr(DL, 8'h34);
        #1;
        chk("valid after low", 64'h0, flash_buf_valid);
        rdc("low byte", DL, 8'h34);
        wr(AH, 8'hff);
        rdc("addr high", AH, 8'h7f);
        for (int a = 6; a < 12; a++) begin
            wr(a[3:0], 8'h50 + 8'(a));
            rdc("data reg", a[3:0], 8'h50 + 8'(a));
        end
        $display("test regs done");
    endtask
    task automatic t_keys();
        wr(CM, 8'h80);
        rdc("enable by write", CM, 8'h00);
        unlock(8'h41, 8'h00);
        unlock(fsp_pkg::KEY_B5, 8'h80);
        $display("test keys done");
    endtask
    task automatic t_page_end();
        wr(AL, 8'h7e);
        wr(AH, 8'h00);
        wr(DH, 8'h12);
        #1;
        chk("word 62", 16'h1234, flash_buf_word[62]);
        chk("valid", 64'h4000_0000_0000_0000, flash_buf_valid);
        rdc("addr low", AL, 8'h7f);
        wr(DH, 8'h56);
        #1;
        chk("word 63", 16'h5634, flash_buf_word[63]);
        rdc("addr held", AL, 8'h7f);
        rdc("addr high", AH, 8'h00);
        wr(CA, 8'h01);
        rdc("clear done", CA, 8'h00);
        chk("valid cleared", 64'h0, flash_buf_valid);
        $display("test page end done");
    endtask
    task automatic t_erase();
        int e0;
        int e1;
        tag_page();
        run_op(8'h94, 1'b1, e0);
        chk("erase kind", 1'b1, seen_erase);
        chk("erase page", 9'h002, seen_page);
        rdc("start cleared", CM, 8'h90);
        for (int i = 0; i < 64; i++) begin
            rd_addr = 15'h0080 + 15'(i);
            #1;
            chk("blank word", 16'h0000, rd_data);
        end
        wr(CA, 8'h02);
        tag_page();
        run_op(8'h94, 1'b1, e1);
        chk("erase time step", EL - ES, e1 - e0);
        $display("test erase done");
    endtask
    task automatic t_write();
        int w0;
        int w1;
        load3();
        run_op(8'h84, 1'b1, w1);
        chk("write kind", 1'b0, seen_erase);
        chk("valid after write", 64'h0, flash_buf_valid);
        for (int i = 0; i < 3; i++) begin
            rd_addr = 15'h0080 + 15'(i);
            #1;
            chk("written word", {8'ha0 + 8'(i), 8'h05 + 8'(i)}, rd_data);
        end
        wr(CA, 8'h00);
        load3();
        run_op(8'h84, 1'b1, w0);
        chk("write time step", WL - WS, w1 - w0);
        $display("test write done");
    endtask
    task automatic t_refuse();
        int d;
        for (int m = 2; m < 8; m++) begin
            run_op({1'b1, 3'(m), 4'h4}, 1'b0, d);
        end
        rdc("start refused", CM, 8'hf0);
        wr(CM, 8'h10);
        rdc("disabled", CM, 8'h10);
        run_op(8'h14, 1'b0, d);
        $display("test refuse done");
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_keys();
        t_page_end();
        t_erase();
        t_write();
        t_refuse();
        complete_run();
    end
endmodule // tb_flash_selfprogram_erase_write
